// *** rtl/eirq_pkg.sv ***
// constants and types shared by the external interrupt latch block
package eirq_pkg;

   // wishbone geometry: byte address, one 32-bit word per register
   localparam int ADR_W = 10;
   localparam int DAT_W = 32;
   localparam int SEL_W = 4;
   localparam int IDX_W = 8;
   localparam int IDX_LSB = 2;

   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_STATUS_CONTROL = 8'h1d;
   localparam logic [IDX_W-1:0] IDX_EVT_STATUS = 8'h20;
   localparam logic [IDX_W-1:0] IDX_EVT_MASK = 8'h21;

   // status/control field positions
   localparam int BIT_EDGE_LEVEL_SELECT = 0;
   localparam int BIT_REQUEST_MASK = 1;
   localparam int BIT_REQUEST_ACKNOWLEDGE = 2;
   localparam int BIT_REQUEST_PENDING_FLAG = 3;

   // reset values of the control bits
   localparam logic RST_EDGE_LEVEL_SELECT = 1'b0;
   localparam logic RST_REQUEST_MASK = 1'b0;
   localparam logic RST_PENDING = 1'b0;

   // event status/mask layout
   localparam int EVT_W = 2;
   localparam int EVT_LATCHED = 0;
   localparam int EVT_ACKED = 1;
   localparam logic [EVT_W-1:0] RST_EVT_STATUS = 2'h0;
   localparam logic [EVT_W-1:0] RST_EVT_MASK = 2'h3;

   // service routine vector pair
   localparam logic [15:0] VECTOR_ADDR_HI = 16'hfffa;
   localparam logic [15:0] VECTOR_ADDR_LO = 16'hfffb;

   // synchroniser reset level (low, so a pin held low at reset gives no edge)
   localparam logic RST_SYNC = 1'b0;

   // latch states
   typedef enum logic [1:0] {
      EIRQ_IDLE,
      EIRQ_PENDING,
      EIRQ_ACKED_WAIT_HIGH
   } eirq_state_t;

endpackage

// *** rtl/eirq_reg_if.sv ***
// register access carrier between the bus slave and the latch core
`timescale 1ns/1ps
interface eirq_reg_if;
   logic wr_en;
   logic [eirq_pkg::IDX_W-1:0] idx;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport slave (output wr_en, output idx, output wdata, input rdata);
   modport core (input wr_en, input idx, input wdata, output rdata);
endinterface

// *** rtl/eirq_sync.sv ***
// two-flop pin synchroniser with falling edge detector
`timescale 1ns/1ps
module eirq_sync (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // asynchronous pin, active low
   input wire logic pin_n_i,
   // synchronised level and falling edge pulse
   output logic level_o,
   output logic fall_o
);

   logic meta_ff;
   logic sync_ff;
   logic prev_ff;
   logic nxt_meta;
   logic nxt_sync;
   logic nxt_prev;

   always_comb begin
      nxt_meta = pin_n_i;
      nxt_sync = meta_ff;
      nxt_prev = sync_ff;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_ff <= eirq_pkg::RST_SYNC;
         sync_ff <= eirq_pkg::RST_SYNC;
         prev_ff <= eirq_pkg::RST_SYNC;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
         prev_ff <= nxt_prev;
      end
   end

   assign level_o = sync_ff;
   // high sample followed by low sample
   assign fall_o = prev_ff & ~sync_ff;

endmodule

// *** rtl/eirq_wb_slave.sv ***
// classic wishbone slave, one wait state, 8-bit registers in the low lane
`timescale 1ns/1ps
module eirq_wb_slave (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [eirq_pkg::ADR_W-1:0] adr_i,
   input wire logic [eirq_pkg::SEL_W-1:0] sel_i,
   input wire logic [eirq_pkg::DAT_W-1:0] dat_i,
   output logic [eirq_pkg::DAT_W-1:0] dat_o,
   output logic ack_o,
   // register side
   eirq_reg_if.slave regs
);

   logic ack_ff;
   logic nxt_ack;
   logic [eirq_pkg::DAT_W-1:0] dat_ff;
   logic [eirq_pkg::DAT_W-1:0] nxt_dat;

   // the write lands on the edge where the master sees ack
   always_comb begin
      nxt_ack = cyc_i & stb_i & ~ack_ff;
      nxt_dat = dat_ff;
      if (cyc_i & stb_i & ~ack_ff & ~we_i) begin
         nxt_dat = {24'h000000, regs.rdata};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h00000000;
      end else begin
         ack_ff <= nxt_ack;
         dat_ff <= nxt_dat;
      end
   end

   assign regs.idx = adr_i[eirq_pkg::IDX_LSB +: eirq_pkg::IDX_W];
   assign regs.wdata = dat_i[7:0];
   assign regs.wr_en = cyc_i & stb_i & we_i & ack_ff & sel_i[0];
   assign ack_o = ack_ff;
   assign dat_o = dat_ff;

endmodule

// *** rtl/eirq_top.sv ***
// external interrupt request latch with status/control register
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
module eirq_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone register bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [eirq_pkg::ADR_W-1:0] adr_i,
   input wire logic [eirq_pkg::SEL_W-1:0] sel_i,
   input wire logic [eirq_pkg::DAT_W-1:0] dat_i,
   output logic [eirq_pkg::DAT_W-1:0] dat_o,
   output logic ack_o,
   // external pin, active low
   input wire logic ext_int_pin_n_i,
   // cpu side
   input wire logic fetch_strobe_i,
   input wire logic [15:0] fetch_addr_i,
   input wire logic cpu_int_mask_i,
   output logic [15:0] vector_addr_hi_o,
   output logic [15:0] vector_addr_lo_o,
   output logic irq_request_o,
   output logic cpu_irq_o,
   output logic request_pending_o,
   output logic request_acknowledge_o,
   // pin level for branch instructions
   output logic branch_on_pin_high_o,
   output logic branch_on_pin_low_o,
   // event interrupt
   output logic irq_o
);

   // register decode helper, shared by reads and writes
   function automatic logic reg_hit(input logic [eirq_pkg::IDX_W-1:0] idx,
                                    input logic [eirq_pkg::IDX_W-1:0] target);
      reg_hit = (idx == target);
   endfunction

   // sticky bits: a new event wins over a one-to-clear written in the same cycle
   function automatic logic [eirq_pkg::EVT_W-1:0] sticky(
         input logic [eirq_pkg::EVT_W-1:0] cur,
         input logic [eirq_pkg::EVT_W-1:0] set,
         input logic [eirq_pkg::EVT_W-1:0] clr);
      sticky = set | (cur & ~clr);
   endfunction

   eirq_reg_if regs ();

   logic pin_level;
   logic pin_fall;

   eirq_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_n_i(ext_int_pin_n_i),
      .level_o(pin_level),
      .fall_o(pin_fall)
   );

   eirq_wb_slave u_wb (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cyc_i(cyc_i),
      .stb_i(stb_i),
      .we_i(we_i),
      .adr_i(adr_i),
      .sel_i(sel_i),
      .dat_i(dat_i),
      .dat_o(dat_o),
      .ack_o(ack_o),
      .regs(regs)
   );

   // write decode
   logic wr_ctrl;
   logic wr_evt_status;
   logic wr_evt_mask;

   assign wr_ctrl = regs.wr_en & reg_hit(regs.idx, eirq_pkg::IDX_STATUS_CONTROL);
   assign wr_evt_status = regs.wr_en & reg_hit(regs.idx, eirq_pkg::IDX_EVT_STATUS);
   assign wr_evt_mask = regs.wr_en & reg_hit(regs.idx, eirq_pkg::IDX_EVT_MASK);

   // ------------------------------------------------------------------
   // control bits
   // ------------------------------------------------------------------
   logic edge_level_select_ff;
   logic request_mask_ff;
   logic nxt_edge_level_select;
   logic nxt_request_mask;

   always_comb begin
      nxt_edge_level_select = edge_level_select_ff;
      nxt_request_mask = request_mask_ff;
      if (wr_ctrl) begin
         nxt_edge_level_select = regs.wdata[eirq_pkg::BIT_EDGE_LEVEL_SELECT];
         nxt_request_mask = regs.wdata[eirq_pkg::BIT_REQUEST_MASK];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         edge_level_select_ff <= eirq_pkg::RST_EDGE_LEVEL_SELECT;
         request_mask_ff <= eirq_pkg::RST_REQUEST_MASK;
      end else begin
         edge_level_select_ff <= nxt_edge_level_select;
         request_mask_ff <= nxt_request_mask;
      end
   end

   // ------------------------------------------------------------------
   // acknowledge sources
   // ------------------------------------------------------------------
   logic sw_ack;
   logic fetch_ack;
   logic any_ack;
   logic pending;
   logic routed;

   // the write-only acknowledge bit never stores, it only pulses
   assign sw_ack = wr_ctrl & regs.wdata[eirq_pkg::BIT_REQUEST_ACKNOWLEDGE];
   // only a fetch that this request caused may clear it
   assign fetch_ack = fetch_strobe_i & (fetch_addr_i == eirq_pkg::VECTOR_ADDR_HI)
                      & routed;
   assign any_ack = sw_ack | fetch_ack;

   // ------------------------------------------------------------------
   // request latch
   // ------------------------------------------------------------------
   eirq_pkg::eirq_state_t state_ff;
   eirq_pkg::eirq_state_t nxt_state;
   logic pin_low;
   logic level_set;

   assign pin_low = ~pin_level;
   // low level only sets the latch in level mode (edge_level_select_ff set)
   assign level_set = edge_level_select_ff & pin_low;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         eirq_pkg::EIRQ_IDLE: begin
            if (pin_fall | level_set) begin
               nxt_state = eirq_pkg::EIRQ_PENDING;
            end
         end
         eirq_pkg::EIRQ_PENDING: begin
            if (pin_fall) begin
               nxt_state = eirq_pkg::EIRQ_PENDING;
            end else if (any_ack & ~edge_level_select_ff) begin
               nxt_state = eirq_pkg::EIRQ_IDLE;
            end else if (any_ack & pin_low) begin
               nxt_state = eirq_pkg::EIRQ_ACKED_WAIT_HIGH;
            end else if (any_ack) begin
               nxt_state = eirq_pkg::EIRQ_IDLE;
            end
         end
         eirq_pkg::EIRQ_ACKED_WAIT_HIGH: begin
            // still pending; a mode change back to edge-only ends the wait
            if (pin_fall) begin
               nxt_state = eirq_pkg::EIRQ_PENDING;
            end else if (~edge_level_select_ff | ~pin_low) begin
               nxt_state = eirq_pkg::EIRQ_IDLE;
            end
         end
         default: begin
            nxt_state = eirq_pkg::EIRQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= eirq_pkg::EIRQ_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign pending = (state_ff != eirq_pkg::EIRQ_IDLE);
   assign routed = pending & ~request_mask_ff;

   // ------------------------------------------------------------------
   // event status and mask
   // ------------------------------------------------------------------
   logic [eirq_pkg::EVT_W-1:0] evt_status_ff;
   logic [eirq_pkg::EVT_W-1:0] evt_mask_ff;
   logic [eirq_pkg::EVT_W-1:0] nxt_evt_status;
   logic [eirq_pkg::EVT_W-1:0] nxt_evt_mask;
   logic [eirq_pkg::EVT_W-1:0] evt_set;
   logic [eirq_pkg::EVT_W-1:0] evt_clr;
   logic new_latch;

   assign new_latch = pending == 1'b0 ? (nxt_state != eirq_pkg::EIRQ_IDLE) : pin_fall;

   always_comb begin
      evt_set = '0;
      evt_set[eirq_pkg::EVT_LATCHED] = new_latch;
      evt_set[eirq_pkg::EVT_ACKED] = any_ack & pending;
      evt_clr = wr_evt_status ? regs.wdata[eirq_pkg::EVT_W-1:0] : '0;
      nxt_evt_status = sticky(evt_status_ff, evt_set, evt_clr);
      nxt_evt_mask = evt_mask_ff;
      if (wr_evt_mask) begin
         nxt_evt_mask = regs.wdata[eirq_pkg::EVT_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         evt_status_ff <= eirq_pkg::RST_EVT_STATUS;
         evt_mask_ff <= eirq_pkg::RST_EVT_MASK;
      end else begin
         evt_status_ff <= nxt_evt_status;
         evt_mask_ff <= nxt_evt_mask;
      end
   end

   // ------------------------------------------------------------------
   // registered cpu-facing outputs and the constant vector addresses
   // ------------------------------------------------------------------
   logic irq_request_ff;
   logic cpu_irq_ff;
   logic pending_ff;
   logic ack_pulse_ff;
   logic pin_high_ff;
   logic irq_ff;
   logic nxt_irq_request;
   logic nxt_cpu_irq;
   logic nxt_pending;
   logic nxt_ack_pulse;
   logic nxt_pin_high;
   logic nxt_irq;

   // outputs except the pin level are flopped from next-state values, so they match the latch in the same cycle and still come from clean flops
   always_comb begin
      nxt_pending = (nxt_state != eirq_pkg::EIRQ_IDLE);
      nxt_irq_request = nxt_pending & ~nxt_request_mask;
      nxt_cpu_irq = nxt_irq_request & ~cpu_int_mask_i;
      nxt_ack_pulse = any_ack;
      nxt_pin_high = pin_level;
      nxt_irq = |(nxt_evt_status & ~nxt_evt_mask);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_request_ff <= 1'b0;
         cpu_irq_ff <= 1'b0;
         pending_ff <= eirq_pkg::RST_PENDING;
         ack_pulse_ff <= 1'b0;
         pin_high_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         irq_request_ff <= nxt_irq_request;
         cpu_irq_ff <= nxt_cpu_irq;
         pending_ff <= nxt_pending;
         ack_pulse_ff <= nxt_ack_pulse;
         pin_high_ff <= nxt_pin_high;
         irq_ff <= nxt_irq;
      end
   end

   assign irq_request_o = irq_request_ff;
   assign cpu_irq_o = cpu_irq_ff;
   assign request_pending_o = pending_ff;
   assign request_acknowledge_o = ack_pulse_ff;
   assign branch_on_pin_high_o = pin_high_ff;
   assign branch_on_pin_low_o = ~pin_high_ff;
   assign irq_o = irq_ff;
   assign vector_addr_hi_o = eirq_pkg::VECTOR_ADDR_HI;
   assign vector_addr_lo_o = eirq_pkg::VECTOR_ADDR_LO;

   // ------------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------------
   logic [7:0] rd_ctrl;

   always_comb begin
      rd_ctrl = 8'h00;
      rd_ctrl[eirq_pkg::BIT_EDGE_LEVEL_SELECT] = edge_level_select_ff;
      rd_ctrl[eirq_pkg::BIT_REQUEST_MASK] = request_mask_ff;
      rd_ctrl[eirq_pkg::BIT_REQUEST_PENDING_FLAG] = pending;
      if (reg_hit(regs.idx, eirq_pkg::IDX_STATUS_CONTROL)) begin
         regs.rdata = rd_ctrl;
      end else if (reg_hit(regs.idx, eirq_pkg::IDX_EVT_STATUS)) begin
         regs.rdata = {6'h00, evt_status_ff};
      end else if (reg_hit(regs.idx, eirq_pkg::IDX_EVT_MASK)) begin
         regs.rdata = {6'h00, evt_mask_ff};
      end else begin
         regs.rdata = 8'h00;
      end
   end

endmodule

// *** dv/eirq_pin_model.sv ***
// external interrupt source that pulls the pin low on demand
`timescale 1ns/1ps
module eirq_pin_model (
   // clock
   input wire logic clk_i,
   // request to hold the pin low
   input wire logic hold_low_i,
   // pin, active low
   output logic pin_n_o
);
   // the pin has a pull-up, so released means high; the source only ever pulls low
   initial pin_n_o = 1'b1;
   always @(posedge clk_i) begin
      pin_n_o <= ~hold_low_i;
   end
endmodule

// *** dv/eirq_checker.sv ***
// port assertions for the external interrupt latch
`timescale 1ns/1ps
module eirq_checker (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [eirq_pkg::ADR_W-1:0] adr_i,
   input wire logic [eirq_pkg::SEL_W-1:0] sel_i,
   input wire logic [eirq_pkg::DAT_W-1:0] dat_i,
   input wire logic [eirq_pkg::DAT_W-1:0] dat_o,
   input wire logic ack_o,
   // pin and cpu side
   input wire logic ext_int_pin_n_i,
   input wire logic fetch_strobe_i,
   input wire logic cpu_int_mask_i,
   input wire logic [15:0] vector_addr_hi_o,
   input wire logic irq_request_o,
   input wire logic cpu_irq_o,
   input wire logic request_pending_o,
   input wire logic request_acknowledge_o,
   input wire logic branch_on_pin_high_o,
   input wire logic branch_on_pin_low_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic ctrl_wr;
   logic mask_sh_ff;
   logic nxt_mask_sh;
   assign ctrl_wr = ack_o && we_i && sel_i[0] && adr_i[9:2] == eirq_pkg::IDX_STATUS_CONTROL;
   // shadow of the local mask, taken from bus writes only
   always_comb begin
      nxt_mask_sh = ctrl_wr ? dat_i[1] : mask_sh_ff;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_sh_ff <= 1'b0;
      end else begin
         mask_sh_ff <= nxt_mask_sh;
      end
   end
   // extra high samples cover the synchroniser refilling after reset
   property p_fall_sets;
      (ext_int_pin_n_i [*4] ##1 !ext_int_pin_n_i [*4]) and (!cyc_i && !fetch_strobe_i) [*8]
         |-> ##[0:2] request_pending_o;
   endproperty
   a_fall_sets: assert property (p_fall_sets) else $error("fall did not latch");
   property p_req_pend;
      irq_request_o |-> request_pending_o;
   endproperty
   a_req_pend: assert property (p_req_pend) else $error("request without latch");
   property p_mask;
      irq_request_o |-> !mask_sh_ff;
   endproperty
   a_mask: assert property (p_mask) else $error("masked request forwarded");
   property p_cpu;
      cpu_irq_o |-> !$past(cpu_int_mask_i);
   endproperty
   a_cpu: assert property (p_cpu) else $error("cpu mask ignored");
   property p_pin_hi;
      ext_int_pin_n_i [*5] |-> branch_on_pin_high_o && !branch_on_pin_low_o;
   endproperty
   a_pin_hi: assert property (p_pin_hi) else $error("pin high not shown");
   property p_pin_lo;
      !ext_int_pin_n_i [*5] |-> branch_on_pin_low_o && !branch_on_pin_high_o;
   endproperty
   a_pin_lo: assert property (p_pin_lo) else $error("pin low not shown");
   property p_read0;
      ack_o && !we_i |-> dat_o[31:4] == 28'h0 && !dat_o[2];
   endproperty
   a_read0: assert property (p_read0) else $error("reserved bits read nonzero");
   property p_swack;
      ctrl_wr && dat_i[2] |-> ##[1:2] request_acknowledge_o;
   endproperty
   a_swack: assert property (p_swack) else $error("no acknowledge pulse");
   property p_vec;
      vector_addr_hi_o == 16'hfffa;
   endproperty
   a_vec: assert property (p_vec) else $error("wrong vector address");
   property p_ack;
      $rose(cyc_i && stb_i) |=> ack_o ##1 !ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("bad bus answer");
endmodule
bind eirq_top eirq_checker u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
   .dat_o, .ack_o, .ext_int_pin_n_i, .fetch_strobe_i, .cpu_int_mask_i, .vector_addr_hi_o,
   .irq_request_o, .cpu_irq_o, .request_pending_o, .request_acknowledge_o,
   .branch_on_pin_high_o, .branch_on_pin_low_o);

// *** dv/testbench.sv ***
// self-checking bench for the external interrupt latch
`timescale 1ns/1ps
module testbench;
   localparam logic [9:0] A_CTL = {eirq_pkg::IDX_STATUS_CONTROL, 2'b00};
   localparam logic [9:0] A_EVS = {eirq_pkg::IDX_EVT_STATUS, 2'b00};
   localparam logic [9:0] A_EVM = {eirq_pkg::IDX_EVT_MASK, 2'b00};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [9:0] adr_i = 10'h0;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic fetch_strobe_i = 1'b0;
   logic [15:0] fetch_addr_i = 16'h0;
   logic cpu_int_mask_i = 1'b0;
   logic hold_low = 1'b0;
   logic [31:0] dat_o;
   logic [15:0] vector_addr_hi_o;
   logic [15:0] vector_addr_lo_o;
   logic ack_o, ext_int_pin_n_i, irq_request_o, cpu_irq_o, request_pending_o;
   logic request_acknowledge_o, branch_on_pin_high_o, branch_on_pin_low_o, irq_o;
   logic [7:0] exp_q[$];
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int unsigned seed;
   eirq_top dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .ext_int_pin_n_i, .fetch_strobe_i, .fetch_addr_i, .cpu_int_mask_i, .vector_addr_hi_o,
      .vector_addr_lo_o, .irq_request_o, .cpu_irq_o, .request_pending_o,
      .request_acknowledge_o, .branch_on_pin_high_o, .branch_on_pin_low_o, .irq_o);
   eirq_pin_model src (.clk_i(clk_i), .hold_low_i(hold_low), .pin_n_o(ext_int_pin_n_i));
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // one classic cycle; ack is sampled at the rising edge and the release follows that edge
   task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [7:0] e);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'h1;
      dat_i <= {24'h0, d};
      if (!w) exp_q.push_back(e);
      do @(posedge clk_i); while (ack_o !== 1'b1);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic pins(input logic low, input int n);
      hold_low <= low;
      settle(n);
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 6000) begin
         bad_count++;
         tally_and_finish();
      end else if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
         check("read data", dat_o[7:0], exp_q.pop_front());
      end
   end
   initial begin
      seed = $urandom(32'h3bee);
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      settle(6);
      wb(1'b0, A_CTL, 8'h00, 8'h00);
      wb(1'b0, A_EVM, 8'h00, 8'h03);
      wb(1'b0, {8'h22 + 8'($urandom % 200), 2'b00}, 8'h00, 8'h00);
      check("vector hi", vector_addr_hi_o, 16'hfffa);
      check("vector lo", vector_addr_lo_o, 16'hfffb);
      // edge mode: short random pulse, event interrupt masked until opened
      pins(1'b1, 2 + $urandom % 4);
      pins(1'b0, 6);
      check("pending", request_pending_o, 1);
      check("irq", irq_o, 0);
      wb(1'b1, A_EVM, 8'h02, 8'h00);
      settle(2);
      check("irq", irq_o, 1);
      wb(1'b0, A_EVS, 8'h00, 8'h01);
      wb(1'b1, A_EVS, 8'h01, 8'h00);
      settle(2);
      check("irq", irq_o, 0);
      wb(1'b1, A_CTL, {4'($urandom), 4'b1010}, 8'h00);
      settle(2);
      check("request", irq_request_o, 0);
      wb(1'b0, A_CTL, 8'h00, 8'h0a);
      wb(1'b1, A_CTL, 8'h04, 8'h00);
      settle(2);
      check("pending", request_pending_o, 0);
      // a fall after the acknowledge latches again; a vector fetch clears it
      pins(1'b1, 5);
      pins(1'b0, 6);
      check("pending", request_pending_o, 1);
      check("request", irq_request_o, 1);
      @(posedge clk_i);
      fetch_strobe_i <= 1'b1;
      fetch_addr_i <= 16'hfffa;
      @(posedge clk_i);
      fetch_strobe_i <= 1'b0;
      settle(3);
      check("pending", request_pending_o, 0);
      // both events seen so far: the latch by the fall, the acknowledge of a pending request
      wb(1'b0, A_EVS, 8'h00, 8'h03);
      wb(1'b1, A_EVS, 8'h03, 8'h00);
      // cpu mask gating; edge-only acknowledge clears while the pin stays low
      @(posedge clk_i);
      cpu_int_mask_i <= 1'b1;
      pins(1'b1, 8);
      check("cpu irq", cpu_irq_o, 0);
      @(posedge clk_i);
      cpu_int_mask_i <= 1'b0;
      settle(3);
      check("cpu irq", cpu_irq_o, 1);
      wb(1'b1, A_CTL, 8'h04, 8'h00);
      settle(2);
      check("pending", request_pending_o, 0);
      check("pin low", {branch_on_pin_high_o, branch_on_pin_low_o}, 2'b01);
      pins(1'b0, 6);
      check("pin high", {branch_on_pin_high_o, branch_on_pin_low_o}, 2'b10);
      // level mode: acknowledge first, the service routine also masks
      wb(1'b1, A_CTL, 8'h01, 8'h00);
      pins(1'b1, 8);
      wb(1'b1, A_CTL, 8'h07, 8'h00);
      settle(4);
      check("pending", request_pending_o, 1);
      wb(1'b0, A_CTL, 8'h00, 8'h0b);
      pins(1'b0, 6);
      check("pending", request_pending_o, 0);
      // level mode: pin released first, acknowledge afterwards
      wb(1'b1, A_CTL, 8'h01, 8'h00);
      pins(1'b1, 6);
      pins(1'b0, 6);
      check("pending", request_pending_o, 1);
      wb(1'b1, A_CTL, 8'h05, 8'h00);
      settle(3);
      check("pending", request_pending_o, 0);
      // reset in mid-run with the pin held low in level mode
      wb(1'b1, A_CTL, 8'h01, 8'h00);
      pins(1'b1, 6);
      @(posedge clk_i);
      rst_i <= 1'b1;
      settle(2);
      @(posedge clk_i);
      rst_i <= 1'b0;
      settle(4);
      check("pending", request_pending_o, 0);
      wb(1'b0, A_CTL, 8'h00, 8'h00);
      pins(1'b0, 4);
      tally_and_finish();
   end
endmodule
